// File: uart_wake_consts.vh
// constants for the wake-capable receive channel and its baud generator
`ifndef UART_WAKE_CONSTS_VH
`define UART_WAKE_CONSTS_VH

`define PRESCALE_WIDTH 15
`define SCALE_FIELD_WIDTH 4
`define DIV_FIELD_HI 15
`define DIV_FIELD_LO 9
`define DIV_MIN_LEGAL 7'h02
`define DIV_MAX_LEGAL 7'h7f
`define DATA_WIDTH 9
`define FIFO_DEPTH 8
`define FIFO_ADDR_WIDTH 3
`define BITS_SHORT 4'h8
`define BITS_LONG 4'h9
`define RST_PRESCALE 15'h0000
`define RST_DIVISOR 7'h02
`define RST_SCALE 4'h0
`define RST_WORD 9'h000

`endif

// File: uart_rx_fifo.v
// receive word buffer with registered read data and valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none

module uart_rx_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire nrst,
  input wire in_valid,
  input wire [WIDTH-1:0] in_data,
  output wire in_ready,
  output reg out_valid,
  output reg [WIDTH-1:0] out_data,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  // count excludes the word already parked in the output register
  assign in_ready = (count != DEPTH[AW:0]);
  assign push = in_valid && in_ready;
  assign pop = (count != {(AW+1){1'b0}}) && (!out_valid || out_ready);

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
        out_data <= mem[rd_ptr];
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      case ({push, pop})
        2'b10: count <= count + {{AW{1'b0}}, 1'b1};
        2'b01: count <= count - {{AW{1'b0}}, 1'b1};
        default: count <= count;
      endcase
    end
  end
endmodule

`default_nettype wire

// File: uart_rx_wake.v
// wake-capable asynchronous receive channel with prescaler and baud divider
//
// Functional notes
// - error irq enable low: never any error interrupt
// - end interrupt still raised for every frame
// - enable high, suppress low: errors raise interrupt
// - enable high, suppress high: no error interrupt
// - suppress high: error flags stay untouched
// - baud equals op clock over (divisor+1) over two
// - divisor values two through 127 accepted
// - source bit picks low or high prescaler
// - prescaler field n divides clock by 2^n
// - stopped and wake enabled: start bit starts reception
`timescale 1ns/10ps
`default_nettype none
`include "uart_wake_consts.vh"

module uart_rx_wake (
  input wire clk,
  input wire nrst,
  input wire receive_pin,
  input wire channel_start,
  input wire channel_stop_trigger,
  input wire op_clock_source_select,
  input wire [`SCALE_FIELD_WIDTH-1:0] low_prescaler_field,
  input wire [`SCALE_FIELD_WIDTH-1:0] high_prescaler_field,
  input wire [`DIV_FIELD_HI:`DIV_FIELD_LO] channel_data_divisor_reg,
  input wire nine_bit_mode,
  input wire parity_enable,
  input wire parity_odd,
  input wire rx_error_irq_enable,
  input wire wake_error_suppress,
  input wire wake_receive_enable,
  input wire cpu_stopped,
  input wire [2:0] error_flag_clear,
  input wire rx_ready,
  output reg channel_run_status,
  output reg parity_error_flag,
  output reg framing_error_flag,
  output reg overrun_error_flag,
  output reg rx_error_irq,
  output reg rx_end_irq,
  output wire rx_valid,
  output wire [`DATA_WIDTH-1:0] rx_data
);
  localparam [2:0] ST_IDLE = 3'b000;
  localparam [2:0] ST_START = 3'b001;
  localparam [2:0] ST_DATA = 3'b010;
  localparam [2:0] ST_PARITY = 3'b011;
  localparam [2:0] ST_STOP = 3'b100;

  reg [2:0] state;
  reg [`PRESCALE_WIDTH-1:0] prescale_cnt;
  reg [`SCALE_FIELD_WIDTH-1:0] scale_lat;
  reg [6:0] divisor_lat;
  reg [7:0] tick_cnt;
  reg [3:0] bit_cnt;
  reg [`DATA_WIDTH-1:0] shift;
  reg parity_bad;
  reg pin_prev;
  reg push_valid;
  reg [`DATA_WIDTH-1:0] push_word;
  wire push_ready;
  wire mck_tick;
  wire [7:0] tick_target;
  wire sample;
  wire start_seen;
  wire start_allowed;
  wire [3:0] bits_needed;
  wire [`DATA_WIDTH-1:0] word;
  wire err_parity;
  wire err_framing;
  wire err_overrun;
  wire any_error;
  wire irq_gate;

  // true once per 2^n clocks: low n bits of the free counter all ones
  function prescale_tick;
    input [`PRESCALE_WIDTH-1:0] cnt;
    input [`SCALE_FIELD_WIDTH-1:0] n;
    reg [`PRESCALE_WIDTH-1:0] mask;
    begin
      mask = (15'h0001 << n) - 15'h0001;
      prescale_tick = ((cnt & mask) == mask);
    end
  endfunction

  assign mck_tick = prescale_tick(prescale_cnt, scale_lat);
  // half a bit is divisor+1 op-clock ticks, a whole bit twice that
  assign tick_target = (state == ST_START) ? {1'b0, divisor_lat} : {divisor_lat, 1'b1};
  assign sample = (state != ST_IDLE) && mck_tick && (tick_cnt == tick_target);
  assign start_seen = pin_prev && !receive_pin;
  // in wake mode a start is only trusted once the processor has stopped
  assign start_allowed = channel_run_status && (!wake_receive_enable || cpu_stopped);
  assign bits_needed = nine_bit_mode ? `BITS_LONG : `BITS_SHORT;
  assign word = nine_bit_mode ? shift : {1'b0, shift[`DATA_WIDTH-1:1]};

  assign err_parity = parity_enable && parity_bad;
  assign err_framing = !receive_pin;
  assign err_overrun = !push_ready;
  assign any_error = err_parity || err_framing || err_overrun;
  assign irq_gate = rx_error_irq_enable && !wake_error_suppress;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      channel_run_status <= 1'b0;
      prescale_cnt <= `RST_PRESCALE;
      scale_lat <= `RST_SCALE;
      divisor_lat <= `RST_DIVISOR;
    end else begin
      if (channel_stop_trigger) begin
        channel_run_status <= 1'b0;
      end else if (channel_start && !channel_run_status) begin
        channel_run_status <= 1'b1;
        prescale_cnt <= `RST_PRESCALE;
        // prescaler and divisor settings are frozen for the whole run; edits wait for a restart
        scale_lat <= op_clock_source_select ? high_prescaler_field : low_prescaler_field;
        divisor_lat <= channel_data_divisor_reg;
      end else begin
        prescale_cnt <= prescale_cnt + 15'h0001;
      end
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      tick_cnt <= 8'h00;
      bit_cnt <= 4'h0;
      shift <= `RST_WORD;
      parity_bad <= 1'b0;
      pin_prev <= 1'b1;
    end else begin
      pin_prev <= receive_pin;
      if (!channel_run_status || channel_stop_trigger) begin
        state <= ST_IDLE;
      end else if (state == ST_IDLE) begin
        tick_cnt <= 8'h00;
        if (start_allowed && start_seen) begin
          state <= ST_START;
        end
      end else begin
        if (mck_tick) begin
          tick_cnt <= (tick_cnt == tick_target) ? 8'h00 : tick_cnt + 8'h01;
        end
        if (sample) begin
          case (state)
            ST_START: begin
              // a glitch shorter than half a bit is not a start
              if (receive_pin) begin
                state <= ST_IDLE;
              end else begin
                state <= ST_DATA;
                bit_cnt <= 4'h0;
                parity_bad <= parity_odd;
              end
            end
            ST_DATA: begin
              shift <= {receive_pin, shift[`DATA_WIDTH-1:1]};
              parity_bad <= parity_bad ^ receive_pin;
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == bits_needed - 4'h1) begin
                state <= parity_enable ? ST_PARITY : ST_STOP;
              end
            end
            ST_PARITY: begin
              parity_bad <= parity_bad ^ receive_pin;
              state <= ST_STOP;
            end
            default: begin
              state <= ST_IDLE;
            end
          endcase
        end
      end
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      push_valid <= 1'b0;
      push_word <= `RST_WORD;
      rx_end_irq <= 1'b0;
      rx_error_irq <= 1'b0;
      parity_error_flag <= 1'b0;
      framing_error_flag <= 1'b0;
      overrun_error_flag <= 1'b0;
    end else begin
      rx_end_irq <= 1'b0;
      rx_error_irq <= 1'b0;
      if (push_valid && push_ready) begin
        push_valid <= 1'b0;
      end
      // set beats clear when both land in one cycle
      parity_error_flag <= parity_error_flag & ~error_flag_clear[0];
      framing_error_flag <= framing_error_flag & ~error_flag_clear[1];
      overrun_error_flag <= overrun_error_flag & ~error_flag_clear[2];
      if (sample && state == ST_STOP) begin
        rx_end_irq <= 1'b1;
        rx_error_irq <= any_error && irq_gate;
        if (!err_overrun) begin
          push_valid <= 1'b1;
          push_word <= word;
        end
        if (!wake_error_suppress) begin
          if (err_parity) begin
            parity_error_flag <= 1'b1;
          end
          if (err_framing) begin
            framing_error_flag <= 1'b1;
          end
          if (err_overrun) begin
            overrun_error_flag <= 1'b1;
          end
        end
      end
    end
  end

  // a full buffer drops the new word; overrun is reported only while wake_error_suppress is low
  uart_rx_fifo #(
    .WIDTH(`DATA_WIDTH),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_ADDR_WIDTH)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(push_valid),
    .in_data(push_word),
    .in_ready(push_ready),
    .out_valid(rx_valid),
    .out_data(rx_data),
    .out_ready(rx_ready)
  );
endmodule

`default_nettype wire

// File: uart_tx_model.sv
// remote serial sender driving the receive line
`timescale 1ns/10ps
`default_nettype none
module uart_tx_model (
  input wire logic clk,
  output logic receive_pin
);
  initial receive_pin = 1'h1;
  // start, n data bits lsb first, optional parity, stop, one idle bit; b is the bit length in clocks
  task automatic send(input logic [8:0] w, input int n, input logic pen, input logic par, input logic bad,
                      input int b);
    logic [12:0] f;
    int len;
    f = 13'h1fff;
    f[0] = 1'h0;
    for (int i = 0; i < n; i++) f[i + 1] = w[i];
    len = n + 1;
    if (pen) begin
      f[len] = par;
      len++;
    end
    f[len] = ~bad;
    for (int i = 0; i <= len + 1; i++) begin
      receive_pin <= f[i];
      repeat (b) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// File: uart_rx_wake_asserts.sv
// checker for the wake receive channel
`timescale 1ns/10ps
`default_nettype none
module uart_rx_wake_chk (
  input wire clk,
  input wire nrst,
  input wire channel_start,
  input wire channel_stop_trigger,
  input wire rx_error_irq_enable,
  input wire wake_error_suppress,
  input wire channel_run_status,
  input wire parity_error_flag,
  input wire framing_error_flag,
  input wire overrun_error_flag,
  input wire rx_error_irq,
  input wire rx_end_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  err_needs_en_a: assert property (rx_error_irq |-> $past(rx_error_irq_enable)) else $error("error irq disabled");
  err_suppress_a: assert property (rx_error_irq |-> !$past(wake_error_suppress)) else $error("error irq suppressed");
  err_raised_a: assert property ($rose(parity_error_flag | framing_error_flag | overrun_error_flag)
    && $past(rx_error_irq_enable) |-> rx_error_irq) else $error("no error irq");
  err_with_end_a: assert property (rx_error_irq |-> rx_end_irq) else $error("error irq alone");
  end_pulse_a: assert property (rx_end_irq |=> !rx_end_irq) else $error("end irq too long");
  flags_frozen_a: assert property (wake_error_suppress |=>
    !$rose(parity_error_flag | framing_error_flag | overrun_error_flag)) else $error("flag set");
  flag_at_end_a: assert property ($rose(framing_error_flag) |-> rx_end_irq) else $error("flag early");
  start_run_a: assert property (channel_start && !channel_stop_trigger |=> channel_run_status) else $error("no run");
  stop_halt_a: assert property (channel_stop_trigger |=> !channel_run_status) else $error("no stop");
  end_needs_run_a: assert property (rx_end_irq |-> $past(channel_run_status)) else $error("idle rx");
  cover property (rx_error_irq);
  cover property ($rose(overrun_error_flag));
  cover property ($rose(parity_error_flag));
  cover property (rx_end_irq && !rx_error_irq);
endmodule
bind uart_rx_wake uart_rx_wake_chk i_chk (.*);
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the wake receive channel
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk = 0, nrst = 0, channel_start = 0, channel_stop_trigger = 0, op_clock_source_select = 0;
  logic nine_bit_mode = 0, parity_enable = 0, parity_odd = 0, rx_error_irq_enable = 0;
  logic wake_error_suppress = 0, wake_receive_enable = 0, cpu_stopped = 0, rx_ready = 1;
  logic [3:0] low_prescaler_field = 0, high_prescaler_field = 0;
  logic [15:9] channel_data_divisor_reg = 7'h02;
  logic [2:0] error_flag_clear = 0;
  wire receive_pin, channel_run_status, parity_error_flag, framing_error_flag, overrun_error_flag;
  wire rx_error_irq, rx_end_irq, rx_valid;
  wire [8:0] rx_data;
  int failures = 0, checks_done = 0, cyc = 0, seed = 3, b = 6;
  logic perr = 0;
  logic [8:0] qd[$];
  logic qe[$];
  uart_rx_wake i_dut (
    .clk(clk), .nrst(nrst), .receive_pin(receive_pin), .channel_start(channel_start),
    .channel_stop_trigger(channel_stop_trigger), .op_clock_source_select(op_clock_source_select),
    .low_prescaler_field(low_prescaler_field), .high_prescaler_field(high_prescaler_field),
    .channel_data_divisor_reg(channel_data_divisor_reg), .nine_bit_mode(nine_bit_mode),
    .parity_enable(parity_enable), .parity_odd(parity_odd), .rx_error_irq_enable(rx_error_irq_enable),
    .wake_error_suppress(wake_error_suppress), .wake_receive_enable(wake_receive_enable),
    .cpu_stopped(cpu_stopped), .error_flag_clear(error_flag_clear), .rx_ready(rx_ready),
    .channel_run_status(channel_run_status), .parity_error_flag(parity_error_flag),
    .framing_error_flag(framing_error_flag), .overrun_error_flag(overrun_error_flag),
    .rx_error_irq(rx_error_irq), .rx_end_irq(rx_end_irq), .rx_valid(rx_valid), .rx_data(rx_data)
  );
  uart_tx_model i_tx (.clk(clk), .receive_pin(receive_pin));
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // words are read out for up to 5000 cycles before the queues are checked
  task automatic drain;
    for (int t = 0; t < 5000 && qd.size() > 0; t++) @(posedge clk);
    // a word or an interrupt that never arrived is a fault, not a pass
    chk(qd.size() + qe.size(), 9'h000);
    qd.delete();
    qe.delete();
    $display("test done at %0t", $time);
  endtask
  task automatic restart(input logic s, input logic [3:0] l, input logic [3:0] h, input logic [6:0] d);
    drain();
    channel_stop_trigger <= 1'h1;
    @(posedge clk);
    channel_stop_trigger <= 1'h0;
    op_clock_source_select <= s;
    low_prescaler_field <= l;
    high_prescaler_field <= h;
    channel_data_divisor_reg <= d;
    @(posedge clk);
    channel_start <= 1'h1;
    @(posedge clk);
    channel_start <= 1'h0;
    b = 2 * (d + 1) * (1 << (s ? h : l));
  endtask
  task automatic frame(input logic bad, input logic err, input logic keep);
    logic [8:0] w;
    w = $random(seed) & (nine_bit_mode ? 9'h1ff : 9'h0ff);
    if (keep) qd.push_back(w);
    qe.push_back(err);
    // even parity keeps the ones count even, odd parity odd; perr spoils it on purpose
    i_tx.send(w, nine_bit_mode ? 9 : 8, parity_enable, parity_odd ^ (^w) ^ perr, bad, b);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (rx_end_irq) chk(rx_error_irq, qe.size() ? qe.pop_front() : 'x);
    if (rx_valid && rx_ready) chk(rx_data, qd.size() ? qd.pop_front() : 'x);
    if (cyc == 60000) begin
      failures++;
      close_out();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'h1;
    restart(1'h0, 4'h0, 4'h7, 7'h02);
    frame(1'h0, 1'h0, 1'h1);
    // edits while running must not touch the rate of the next frame
    channel_data_divisor_reg <= 7'h7f;
    low_prescaler_field <= 4'h5;
    frame(1'h0, 1'h0, 1'h1);
    restart(1'h1, 4'h7, 4'h1, 7'h03);
    frame(1'h0, 1'h0, 1'h1);
    restart(1'h0, 4'h2, 4'h0, 7'h05);
    frame(1'h0, 1'h0, 1'h1);
    restart(1'h1, 4'h0, 4'h0, 7'h7f);
    frame(1'h0, 1'h0, 1'h1);
    restart(1'h0, 4'h0, 4'h0, 7'h02);
    for (int i = 0; i < 4; i++) begin
      rx_error_irq_enable <= i[1];
      wake_error_suppress <= i[0];
      @(posedge clk);
      frame(1'h1, i == 2, 1'h1);
      chk(framing_error_flag, !i[0]);
      error_flag_clear <= 3'h7;
      @(posedge clk);
      error_flag_clear <= 3'h0;
    end
    nine_bit_mode <= 1'h1;
    parity_enable <= 1'h1;
    wake_error_suppress <= 1'h0;
    for (int i = 0; i < 4; i++) begin
      parity_odd <= i[0];
      @(posedge clk);
      perr = i[1];
      frame(1'h0, i[1], 1'h1);
      chk(parity_error_flag, i[1]);
      error_flag_clear <= 3'h1;
      @(posedge clk);
      error_flag_clear <= 3'h0;
    end
    perr = 1'h0;
    nine_bit_mode <= 1'h0;
    parity_enable <= 1'h0;
    parity_odd <= 1'h0;
    restart(1'h0, 4'h0, 4'h0, 7'h02);
    wake_receive_enable <= 1'h1;
    @(posedge clk);
    i_tx.send(9'h05a, 8, 1'h0, 1'h0, 1'h0, b);
    cpu_stopped <= 1'h1;
    frame(1'h0, 1'h0, 1'h1);
    drain();
    wake_receive_enable <= 1'h0;
    restart(1'h0, 4'h0, 4'h0, 7'h02);
    rx_ready <= 1'h0;
    wake_error_suppress <= 1'h0;
    rx_error_irq_enable <= 1'h1;
    for (int i = 0; i < 10; i++) frame(1'h0, i == 9, i < 9);
    chk(overrun_error_flag, 1'h1);
    rx_ready <= 1'h1;
    drain();
    close_out();
  end
endmodule
`default_nettype wire
